// [inc/osp_defs.svh]
// Summary of operation
// - Mode field: 0 free run, 1 sync-manager event, 2 SYNC0, 3 SYNC1; writable, reset 1.
// - Cycle time in ns, reset 1 ms; sets local timer, master or SYNC cycle.
// - Read-only shift time in ns from SYNC0 to outputs applied; resets to zero.
// - Read-only supported modes bitmap reads fixed value 0x0c07.
// - Minimum cycle time resets to 250 us in ns; master keeps cycles longer.
// - Read-only SYNC0 to SYNC1 minimum spacing in ns, distributed clock modes.
// - Read-only minimum SYNC1 to outputs applied time in ns.
// - Command write 1 starts local cycle measurement, 0 stops it; resets to 0.
// - While measuring, timing entries take the largest measured values.
// - Starting a new measurement clears previously captured maxima first.
// - Read-only maximum SYNC1 to outputs applied time in ns.
// - 16-bit counter of missed sync-manager events, operational and distributed clock.
// - 16-bit counter of late-finishing or early-starting cycles while operational.
// - 16-bit counter of too-short SYNC0 to SYNC1 spacing, distributed clock.
// - Read-only late output flag, set when last cycle's outputs came late.
// - Subindex zero reads fixed value 0x20.
`ifndef OSP_DEFS_SVH
`define OSP_DEFS_SVH

// ==========================================
// Register addresses
`define OSP_A_SUBIDX 8'h00
`define OSP_A_MODE 8'h01
`define OSP_A_CYCLE 8'h02
`define OSP_A_SHIFT 8'h03
`define OSP_A_SUPP 8'h04
`define OSP_A_MINCYC 8'h05
`define OSP_A_SPACING 8'h06
`define OSP_A_MINDLY 8'h07
`define OSP_A_CMD 8'h08
`define OSP_A_MAXDLY 8'h09
`define OSP_A_MISSED 8'h0b
`define OSP_A_OVERRUN 8'h0c
`define OSP_A_SHORT 8'h0d
`define OSP_A_REPEAT 8'h14
`define OSP_A_LATE 8'h20
`define OSP_A_STATUS 8'h30
`define OSP_A_MASK 8'h31

// ==========================================
// Reset and fixed values
`define OSP_SUBIDX_VAL 8'h20
`define OSP_MODE_RST 16'h0001
`define OSP_CYCLE_RST 32'h000f4240
`define OSP_SUPP_VAL 16'h0c07
`define OSP_MINCYC_RST 32'h0003d090
`define OSP_CMD_START 16'h0001
`define OSP_CMD_STOP 16'h0000
`define OSP_MODE_MAX 16'h0003

// ==========================================
// Mode codes
`define OSP_M_FREE 2'h0
`define OSP_M_SM 2'h1
`define OSP_M_SYNC0 2'h2
`define OSP_M_SYNC1 2'h3

// ==========================================
// Timing and status layout
`define OSP_NS_PER_CLK 32'h0000000a
`define OSP_NS_MAX 32'hffffffff
`define OSP_CNT_MAX 16'hffff
`define OSP_ST_MISSED 0
`define OSP_ST_OVERRUN 1
`define OSP_ST_SHORT 2
`define OSP_ST_LATE 3
`define OSP_ST_W 4

`endif

// [inc/osp_pkg.sv]
package osp_pkg;
   typedef enum logic [1:0]
   {
      OSP_IDLE = 2'b01,
      OSP_MEAS = 2'b10
   } osp_meas_e;
   typedef logic [15:0] osp_cnt_t;
endpackage

// [rtl/osp_monitor.sv]
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "osp_defs.svh"

module osp_monitor
   import osp_pkg::*;
#(
   parameter logic [31:0] SPACING_LIMIT_NS = 32'h000003e8
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata_q,
   // Cycle events
   input wire logic sm2_event,
   input wire logic sync0,
   input wire logic sync1,
   input wire logic out_apply,
   input wire logic cycle_done,
   input wire logic in_operational,
   // Status out
   output logic cycle_start_q,
   output logic meas_active_q,
   output logic irq_q
);

   // ==========================================
   // State
   logic [15:0] mode_q, mode_d;
   logic [31:0] cycle_q, cycle_d;
   logic [31:0] repeat_q, repeat_d;
   logic [15:0] cmd_q, cmd_d;
   logic [31:0] shift_q, shift_d;
   logic [31:0] mincyc_q, mincyc_d;
   logic [31:0] spacing_q, spacing_d;
   logic [31:0] mindly_q, mindly_d;
   logic [31:0] maxdly_q, maxdly_d;
   logic [31:0] t0_q, t0_d, t1_q, t1_d, tc_q, tc_d;
   logic busy_q, busy_d, exceeded_q, exceeded_d;
   logic sm_seen_q, sm_seen_d, pending_q, pending_d, period_seen_q, period_seen_d;
   logic late_q, late_d;
   logic [`OSP_ST_W-1:0] status_q, status_d, mask_q, mask_d, ev;
   logic [31:0] rdata_d;
   logic cycle_start_d, irq_d;
   osp_meas_e meas_q, meas_d;
   osp_cnt_t cnt_q [3];
   osp_cnt_t cnt_d [3];
   logic [1:0] m;
   logic dc, cstart, start_meas, measuring;

   function automatic logic [31:0] sat_add(input logic [31:0] v);
      sat_add = (v > (`OSP_NS_MAX - `OSP_NS_PER_CLK)) ? `OSP_NS_MAX : v + `OSP_NS_PER_CLK;
   endfunction

   function automatic logic [31:0] max32(input logic [31:0] a, input logic [31:0] b);
      max32 = (a > b) ? a : b;
   endfunction

   // ==========================================
   // Next state
   always_comb
   begin
      m = mode_q[1:0];
      dc = (m == `OSP_M_SYNC0) || (m == `OSP_M_SYNC1);
      mode_d = mode_q;
      cycle_d = cycle_q;
      repeat_d = repeat_q;
      cmd_d = cmd_q;
      mask_d = mask_q;
      meas_d = meas_q;
      start_meas = 1'b0;
      if (wr)
      begin
         case (addr)
            `OSP_A_MODE:
            begin
               if (wdata[15:0] <= `OSP_MODE_MAX)
               begin
                  mode_d = wdata[15:0];
               end
            end
            `OSP_A_CYCLE: cycle_d = wdata;
            `OSP_A_REPEAT: repeat_d = wdata;
            `OSP_A_MASK: mask_d = wdata[`OSP_ST_W-1:0];
            `OSP_A_CMD:
            begin
               cmd_d = wdata[15:0];
               if (wdata[15:0] == `OSP_CMD_START)
               begin
                  start_meas = (meas_q != OSP_MEAS);
                  meas_d = OSP_MEAS;
               end
               else
               begin
                  meas_d = OSP_IDLE;
               end
            end
            default: ;
         endcase
      end
      measuring = (meas_q == OSP_MEAS);
      // Cycle start source per mode
      case (m)
         `OSP_M_FREE: cstart = (sat_add(tc_q) >= cycle_q);
         `OSP_M_SM: cstart = sm2_event;
         `OSP_M_SYNC0: cstart = sync0;
         `OSP_M_SYNC1: cstart = sync1;
         default: cstart = 1'b0;
      endcase
      cycle_start_d = cstart;
      t0_d = sync0 ? 32'h0 : sat_add(t0_q);
      t1_d = sync1 ? 32'h0 : sat_add(t1_q);
      tc_d = cstart ? 32'h0 : sat_add(tc_q);
      // Captured maxima
      shift_d = shift_q;
      mincyc_d = mincyc_q;
      spacing_d = spacing_q;
      mindly_d = mindly_q;
      maxdly_d = maxdly_q;
      period_seen_d = period_seen_q;
      if (start_meas)
      begin
         shift_d = 32'h0;
         mincyc_d = 32'h0;
         spacing_d = 32'h0;
         mindly_d = 32'h0;
         maxdly_d = 32'h0;
         period_seen_d = 1'b0;
      end
      else if (measuring)
      begin
         if (out_apply)
         begin
            shift_d = max32(shift_q, t0_q);
            mindly_d = max32(mindly_q, t1_q);
            maxdly_d = max32(maxdly_q, t1_q);
         end
         if (sync1)
         begin
            spacing_d = max32(spacing_q, t0_q);
         end
         if (cstart)
         begin
            if (period_seen_q)
            begin
               mincyc_d = max32(mincyc_q, tc_q);
            end
            period_seen_d = 1'b1;
         end
      end
      // Cycle supervision
      busy_d = cstart | (busy_q & ~cycle_done);
      exceeded_d = cstart ? 1'b0 : exceeded_q | (busy_q & ~cycle_done & (tc_q > cycle_q));
      sm_seen_d = sm2_event | (sm_seen_q & ~sync0);
      pending_d = dc & (sync0 | (pending_q & ~out_apply));
      ev[`OSP_ST_MISSED] = in_operational & dc & sync0 & ~sm_seen_q;
      ev[`OSP_ST_OVERRUN] = in_operational & busy_q & ~cycle_done
                            & (cstart | (~exceeded_q & (tc_q > cycle_q)));
      ev[`OSP_ST_SHORT] = dc & sync1 & (t0_q < SPACING_LIMIT_NS);
      ev[`OSP_ST_LATE] = dc & sync0 & pending_q & ~out_apply;
      late_d = late_q;
      if (dc && sync0)
      begin
         late_d = pending_q & ~out_apply;
      end
      // Sticky status, set wins over write-one clear
      status_d = status_q;
      if (wr && (addr == `OSP_A_STATUS))
      begin
         status_d = status_q & ~wdata[`OSP_ST_W-1:0];
      end
      status_d = status_d | ev;
      irq_d = |(status_d & mask_d);
      // Read mux
      rdata_d = 32'h0;
      if (rd)
      begin
         case (addr)
            `OSP_A_SUBIDX: rdata_d = {24'h0, `OSP_SUBIDX_VAL};
            `OSP_A_MODE: rdata_d = {16'h0, mode_q};
            `OSP_A_CYCLE: rdata_d = cycle_q;
            `OSP_A_SHIFT: rdata_d = shift_q;
            `OSP_A_SUPP: rdata_d = {16'h0, `OSP_SUPP_VAL};
            `OSP_A_MINCYC: rdata_d = mincyc_q;
            `OSP_A_SPACING: rdata_d = spacing_q;
            `OSP_A_MINDLY: rdata_d = mindly_q;
            `OSP_A_CMD: rdata_d = {16'h0, cmd_q};
            `OSP_A_MAXDLY: rdata_d = maxdly_q;
            `OSP_A_MISSED: rdata_d = {16'h0, cnt_q[0]};
            `OSP_A_OVERRUN: rdata_d = {16'h0, cnt_q[1]};
            `OSP_A_SHORT: rdata_d = {16'h0, cnt_q[2]};
            `OSP_A_REPEAT: rdata_d = repeat_q;
            `OSP_A_LATE: rdata_d = {31'h0, late_q};
            `OSP_A_STATUS: rdata_d = {28'h0, status_q};
            `OSP_A_MASK: rdata_d = {28'h0, mask_q};
            default: rdata_d = 32'h0;
         endcase
      end
   end

   // ==========================================
   // Event counters
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_cnt
         always_comb
         begin
            cnt_d[gi] = cnt_q[gi];
            if (ev[gi] && (cnt_q[gi] != `OSP_CNT_MAX))
            begin
               cnt_d[gi] = cnt_q[gi] + 16'h0001;
            end
         end

         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               cnt_q[gi] <= 16'h0000;
            end
            else
            begin
               cnt_q[gi] <= cnt_d[gi];
            end
         end
      end
   endgenerate

   // ==========================================
   // Registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mode_q <= `OSP_MODE_RST;
         cycle_q <= `OSP_CYCLE_RST;
         repeat_q <= 32'h0;
         cmd_q <= `OSP_CMD_STOP;
         meas_q <= OSP_IDLE;
         shift_q <= 32'h0;
         mincyc_q <= `OSP_MINCYC_RST;
         spacing_q <= 32'h0;
         mindly_q <= 32'h0;
         maxdly_q <= 32'h0;
         t0_q <= 32'h0;
         t1_q <= 32'h0;
         tc_q <= 32'h0;
         busy_q <= 1'b0;
         exceeded_q <= 1'b0;
         sm_seen_q <= 1'b0;
         pending_q <= 1'b0;
         period_seen_q <= 1'b0;
         late_q <= 1'b0;
         status_q <= '0;
         mask_q <= '0;
         rdata_q <= 32'h0;
         cycle_start_q <= 1'b0;
         meas_active_q <= 1'b0;
         irq_q <= 1'b0;
      end
      else
      begin
         mode_q <= mode_d;
         cycle_q <= cycle_d;
         repeat_q <= repeat_d;
         cmd_q <= cmd_d;
         meas_q <= meas_d;
         shift_q <= shift_d;
         mincyc_q <= mincyc_d;
         spacing_q <= spacing_d;
         mindly_q <= mindly_d;
         maxdly_q <= maxdly_d;
         t0_q <= t0_d;
         t1_q <= t1_d;
         tc_q <= tc_d;
         busy_q <= busy_d;
         exceeded_q <= exceeded_d;
         sm_seen_q <= sm_seen_d;
         pending_q <= pending_d;
         period_seen_q <= period_seen_d;
         late_q <= late_d;
         status_q <= status_d;
         mask_q <= mask_d;
         rdata_q <= rdata_d;
         cycle_start_q <= cycle_start_d;
         meas_active_q <= (meas_d == OSP_MEAS);
         irq_q <= irq_d;
      end
   end

   // ==========================================
   // Assertions
   a_mode_reset: assert property (@(posedge clk) rst |=> mode_q == `OSP_MODE_RST)
      else $error("mode not reset to one");
   a_mode_write: assert property (@(posedge clk) disable iff (rst)
      wr && addr == `OSP_A_MODE && wdata[15:0] > `OSP_MODE_MAX |=> $stable(mode_q))
      else $error("illegal mode accepted");
   a_subidx_read: assert property (@(posedge clk) disable iff (rst)
      rd && addr == `OSP_A_SUBIDX |=> rdata_q == 32'h00000020)
      else $error("subindex zero wrong");
   a_supp_read: assert property (@(posedge clk) disable iff (rst)
      rd && addr == `OSP_A_SUPP |=> rdata_q == 32'h00000c07)
      else $error("supported modes wrong");
   a_cycle_read: assert property (@(posedge clk) disable iff (rst)
      rd && addr == `OSP_A_CYCLE |=> rdata_q == $past(cycle_q))
      else $error("cycle time readback wrong");
   a_meas_clear: assert property (@(posedge clk) disable iff (rst)
      wr && addr == `OSP_A_CMD && wdata[15:0] == 16'h1 && !meas_active_q
      |=> shift_q == 32'h0 && maxdly_q == 32'h0 && meas_active_q)
      else $error("measure start did not clear");
   a_meas_stop: assert property (@(posedge clk) disable iff (rst)
      wr && addr == `OSP_A_CMD && wdata[15:0] == 16'h0
      |=> !meas_active_q ##1 ($stable(shift_q) || ($past(wr) && $past(addr) == `OSP_A_CMD)))
      else $error("measure stop failed");
   a_shift_max: assert property (@(posedge clk) disable iff (rst)
      meas_active_q && out_apply && !(wr && addr == `OSP_A_CMD)
      |=> shift_q >= $past(t0_q) && maxdly_q >= $past(t1_q))
      else $error("maximum not captured");
   a_missed_inc: assert property (@(posedge clk) disable iff (rst)
      ev[`OSP_ST_MISSED] && cnt_q[0] != 16'hffff |=> cnt_q[0] == $past(cnt_q[0]) + 16'h1)
      else $error("missed count not bumped");
   a_cnt_sat: assert property (@(posedge clk) disable iff (rst)
      cnt_q[1] == 16'hffff |=> cnt_q[1] == 16'hffff)
      else $error("counter wrapped");
   a_short_inc: assert property (@(posedge clk) disable iff (rst)
      ev[`OSP_ST_SHORT] && cnt_q[2] != 16'hffff |=> cnt_q[2] != $past(cnt_q[2]))
      else $error("short count not bumped");
   a_late_flag: assert property (@(posedge clk) disable iff (rst)
      dc && sync0 && pending_q && !out_apply |=> late_q && status_q[`OSP_ST_LATE])
      else $error("late flag not set");
   a_overrun_op: assert property (@(posedge clk) disable iff (rst)
      !in_operational |=> cnt_q[1] == $past(cnt_q[1]))
      else $error("overrun counted outside operational");
   a_irq_level: assert property (@(posedge clk) disable iff (rst)
      irq_q == |(status_q & mask_q))
      else $error("interrupt level mismatch");
   a_late_clear: assert property (@(posedge clk) disable iff (rst)
      dc && sync0 && (!pending_q || out_apply) |=> !late_q)
      else $error("late flag not cleared");
   a_late_hold: assert property (@(posedge clk) disable iff (rst)
      !(dc && sync0) |=> $stable(late_q))
      else $error("late flag moved between sync0 events");
   a_mincyc_max: assert property (@(posedge clk) disable iff (rst)
      meas_active_q && cstart && period_seen_q && !(wr && addr == `OSP_A_CMD) |=> mincyc_q >= $past(tc_q))
      else $error("cycle maximum not captured");
   a_missed_mode: assert property (@(posedge clk) disable iff (rst)
      !dc |=> cnt_q[0] == $past(cnt_q[0]))
      else $error("missed count outside distributed clock");
   a_short_mode: assert property (@(posedge clk) disable iff (rst)
      !dc |=> cnt_q[2] == $past(cnt_q[2]))
      else $error("short count outside distributed clock");
   a_cnt_cap: assert property (@(posedge clk) disable iff (rst)
      cnt_q[0] == `OSP_CNT_MAX |=> cnt_q[0] == `OSP_CNT_MAX)
      else $error("missed counter wrapped");
   a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
      !rd |=> rdata_q == 32'h0)
      else $error("read data not idle");

   c_meas_apply: cover property (@(posedge clk) disable iff (rst) meas_active_q ##[1:20] out_apply);
   c_overrun: cover property (@(posedge clk) disable iff (rst) ev[`OSP_ST_OVERRUN]);
   c_late: cover property (@(posedge clk) disable iff (rst) $rose(late_q));
   c_short: cover property (@(posedge clk) disable iff (rst) ev[`OSP_ST_SHORT] ##1 irq_q);
   c_free_tick: cover property (@(posedge clk) disable iff (rst) m == `OSP_M_FREE && cstart);

endmodule

`default_nettype wire

// [bench/osp_master_model.sv]
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// Fieldbus master cycle model
module osp_master_model
(
   // Clock and control
   input wire logic clk,
   input wire logic go,
   input wire logic [15:0] period,
   input wire logic [15:0] gap1,
   input wire logic [15:0] gap2,
   input wire logic [2:0] skip,
   // Cycle events
   output logic sm2_event,
   output logic sync0,
   output logic sync1,
   output logic out_apply,
   output logic cycle_done
);
   logic [15:0] cnt_q;

   // Cycle position, all events pulse one clock
   always_ff @(posedge clk)
   begin
      cnt_q <= (!go || cnt_q == period - 16'h1) ? 16'h0 : cnt_q + 16'h1;
      sync0 <= go && cnt_q == 16'h0;
      sm2_event <= go && cnt_q == 16'h2 && !skip[0];
      sync1 <= go && cnt_q == gap1;
      out_apply <= go && cnt_q == gap2 && !skip[1];
      cycle_done <= go && cnt_q == gap2 + 16'h1 && !skip[2];
   end
endmodule

`default_nettype wire

// [bench/output_sync_parameter_monitor_tb.sv]
`timescale 1ns/10ps
`default_nettype none

module output_sync_parameter_monitor_tb;
   logic clk, rst, wr, rd, go, in_op, sm2, s0, s1, app, done, cst, meas, irq;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, v;
   logic [15:0] gap1;
   logic [2:0] skip;
   int n_mismatch, checked, n;
   logic [7:0] ra [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
      8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h14, 8'h20};
   logic [31:0] re [16] = '{32'h20, 32'h1, 32'hf4240, 0, 32'hc07, 32'h3d090, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};

   // ==========================================
   // Design and far side
   osp_monitor osp_monitor_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata_q(rdata), .sm2_event(sm2), .sync0(s0), .sync1(s1), .out_apply(app), .cycle_done(done),
      .in_operational(in_op), .cycle_start_q(cst), .meas_active_q(meas), .irq_q(irq));
   osp_master_model osp_master_model_i (.clk(clk), .go(go), .period(16'd300), .gap1(gap1),
      .gap2(16'd150), .skip(skip), .sm2_event(sm2), .sync0(s0), .sync1(s1), .out_apply(app),
      .cycle_done(done));

   // ==========================================
   // Tasks
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      checked++;
      if (!(got >= lo && got <= hi) || $isunknown(got))
      begin
         n_mismatch++;
         $display("BAD t=%0t got %h exp %h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
      logic [31:0] d;
      rd_reg(a, d);
      chk(d, lo, hi);
   endtask

   // ==========================================
   // Clock and watchdog
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial
   begin
      #200us;
      n_mismatch++;
      give_verdict();
   end

   // ==========================================
   // Main sequence
   initial
   begin
      rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h0; wdata = 0;
      go = 1'b0; in_op = 1'b0; gap1 = 16'd120; skip = 3'b000;
      n_mismatch = 0; checked = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 16; i++)
         rd_chk(ra[i], re[i], re[i]);
      wr_reg(8'h00, 0);
      wr_reg(8'h04, 0);
      wr_reg(8'h05, 0);
      rd_chk(8'h00, 32'h20, 32'h20);
      rd_chk(8'h04, 32'hc07, 32'hc07);
      rd_chk(8'h05, 32'h3d090, 32'h3d090);
      for (int m = 0; m < 4; m++)
      begin
         wr_reg(8'h01, m);
         rd_chk(8'h01, m, m);
      end
      wr_reg(8'h01, 32'h4);
      rd_chk(8'h01, 32'h3, 32'h3);
      wr_reg(8'h14, 32'h12345678);
      rd_chk(8'h14, 32'h12345678, 32'h12345678);
      // Free run: local tick every 200 ns
      wr_reg(8'h01, 0);
      wr_reg(8'h02, 32'hc8);
      rd_chk(8'h02, 32'hc8, 32'hc8);
      n = 0;
      repeat (200)
      begin
         @(posedge clk);
         #1 n += cst;
      end
      chk(n, 9, 11);
      // Measurement in SYNC0 mode
      wr_reg(8'h02, 32'hf4240);
      wr_reg(8'h01, 32'h2);
      wr_reg(8'h08, 32'h1);
      #1 chk(meas, 1, 1);
      go <= 1'b1;
      repeat (1500) @(posedge clk);
      go <= 1'b0;
      wr_reg(8'h08, 0);
      #1 chk(meas, 0, 0);
      rd_chk(8'h03, 1480, 1520);
      rd_chk(8'h06, 1180, 1220);
      rd_chk(8'h07, 280, 320);
      rd_chk(8'h09, 280, 320);
      rd_chk(8'h05, 32'hba4, 32'hbb8);
      wr_reg(8'h08, 32'h1);
      rd_chk(8'h03, 0, 0);
      rd_chk(8'h09, 0, 0);
      wr_reg(8'h08, 0);
      // Faults while operational
      in_op <= 1'b1;
      gap1 <= 16'd50;
      skip <= 3'b111;
      go <= 1'b1;
      repeat (900) @(posedge clk);
      go <= 1'b0;
      repeat (5) @(posedge clk);
      rd_chk(8'h0b, 2, 3);
      rd_chk(8'h0c, 1, 3);
      rd_chk(8'h0d, 3, 3);
      rd_chk(8'h20, 1, 1);
      rd_chk(8'h30, 32'hf, 32'hf);
      chk(irq, 0, 0);
      wr_reg(8'h31, 32'h1);
      @(posedge clk);
      #1 chk(irq, 1, 1);
      wr_reg(8'h30, 32'hf);
      @(posedge clk);
      #1 chk(irq, 0, 0);
      rd_chk(8'h30, 0, 0);
      rd_chk(8'h0d, 3, 3);
      // Cycle start from sync-manager event, then from SYNC1
      in_op <= 1'b0;
      skip <= 3'b000;
      for (int k = 1; k < 4; k += 2)
      begin
         wr_reg(8'h01, k);
         n = 0;
         go <= 1'b1;
         repeat (600)
         begin
            @(posedge clk);
            #1 n += cst;
         end
         go <= 1'b0;
         chk(n, 2, 2);
      end
      give_verdict();
   end
endmodule

`default_nettype wire
